// ### core/setpoint_regs_pkg.sv
package setpoint_regs_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_BUCK3 = 8'h18;
  localparam logic [7:0] OFS_BUCKBOOST = 8'h19;
  localparam logic [7:0] OFS_RAMP = 8'h1A;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int LIGHT_LOAD_BIT = 7;
  localparam int TRIGGER_BIT = 7;
  localparam int AUTO_APPLY_BIT = 6;
  localparam logic [7:0] BUCK3_RESET = 8'hBD;
  localparam logic [7:0] BUCKBOOST_RESET = 8'h94;
  localparam logic [7:0] RAMP_RESET = 8'h06;
  localparam logic [5:0] BUCKBOOST_MAX_CODE = 6'h34;
  localparam logic [2:0] RATE_IMMEDIATE = 3'h7;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int BLANK_US = 5000;
  localparam int BLANK_CYCLES = BLANK_US * (CLK_HZ / 1_000_000);
  // Shortest step interval is 2.5 us; each lower code doubles it.
  localparam int STEP_TENTHS_US_MIN = 25;
  localparam int STEP_MIN_CYCLES =
    STEP_TENTHS_US_MIN * (CLK_HZ / 1_000_000) / 10;

endpackage : setpoint_regs_pkg

// ### core/step_timer.sv
`timescale 1ns/100ps
module step_timer
  import setpoint_regs_pkg::*;
#(
  parameter int BASE_CYCLES = STEP_MIN_CYCLES
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset.
  input wire logic run, // Count while high.
  input wire logic [2:0] rate, // Step-rate code.
  output logic tick // One-cycle pulse per step.
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  function automatic logic [15:0] stepLen(input logic [2:0] code);
    logic [15:0] base;
    base = 16'(BASE_CYCLES);
    stepLen = base << (3'h6 - code);
  endfunction : stepLen

  // ---------------------------------------------------------------
  // Interval counter
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!run) begin
      st_nxt.cnt = 16'h0000;
    end else if (st_r.cnt + 16'h0001 >= stepLen(rate)) begin // R13
      st_nxt.cnt = 16'h0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule : step_timer

// ### core/regulator_setpoint_slew_regs.sv
// Summary of operation
// R1: Rail three and buck-boost registers accept writes only when unlocked.
// R2: Writing either rail register blanks its voltage monitoring for 5 ms.
// R3: Bit 7 picks light-load mode, 1 allows pulse-skip, resets to 1.
// R4: Rail three code resets to 3Dh, 0.900 V to 3.400 V.
// R5: Buck-boost code resets to 14h; codes 35h to 3Fh reserved.
// R6: Host avoids reserved buck-boost codes and changes while running.
// R7: Power-up codes may follow the resistor-select input.
// R8: Ramp control only drives rails one and two.
// R9: Host clears pulse-skip on rails one, two before strict downward moves.
// R10: Writing trigger 1 ramps rails one, two to stored codes.
// R11: Trigger bit clears itself when the ramp finishes.
// R12: Auto-apply set lets each code update start a ramp.
// R13: Rate field resets to 6h; codes 0 to 6 give 160 to 2.5 us.
// R14: Rate 7h applies the target at once.
// R15: Timing is per code step, whatever volts the step holds.
// R16: Host sets trigger or auto-apply to change rails one, two.
// R17: Active setpoint moves one code per interval until target.
`timescale 1ns/100ps
module regulator_setpoint_slew_regs
  import setpoint_regs_pkg::*;
#(
  parameter int BLANK_LEN = BLANK_CYCLES,
  parameter logic [7:0] ALT_BUCK3 = 8'hBD,
  parameter logic [7:0] ALT_BUCKBOOST = 8'h94
) (
  input wire logic clk, // 20 MHz clock.
  input wire logic rst, // Synchronous reset.
  input wire logic wrEn, // Register write strobe.
  input wire logic [7:0] addr, // Register offset.
  input wire logic [7:0] wrData, // Write data.
  output logic [7:0] rdData, // Read data, registered.
  input wire logic unlocked, // Password unlock granted.
  input wire logic resistorDefaultSelect, // Strap pin, asynchronous.
  input wire logic [5:0] railOneTarget, // Stored rail one code.
  input wire logic [5:0] railTwoTarget, // Stored rail two code.
  input wire logic railTargetWrite, // Rail one or two code updated.
  output logic [5:0] railOneActive, // Applied rail one code.
  output logic [5:0] railTwoActive, // Applied rail two code.
  output logic [7:0] buckRailThree, // Rail three register.
  output logic [7:0] buckboostRail, // Buck-boost register.
  output logic railThreeBlank, // Rail three monitor blanked.
  output logic buckboostBlank // Buck-boost monitor blanked.
);

  typedef struct packed {
    logic [1:0] strapSync;
    logic strapDone;
    logic [7:0] buck3;
    logic [7:0] bboost;
    logic trig;
    logic autoApply;
    logic [2:0] rate;
    logic ramping;
    logic [5:0] act1;
    logic [5:0] act2;
    logic [22:0] blank3;
    logic [22:0] blankBb;
    logic blank3On;
    logic blankBbOn;
    logic [7:0] rd;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic stepTick;

  function automatic logic [5:0] stepToward(input logic [5:0] cur,
                                            input logic [5:0] tgt);
    if (cur < tgt) begin
      stepToward = cur + 6'h01;
    end else if (cur > tgt) begin
      stepToward = cur - 6'h01;
    end else begin
      stepToward = cur;
    end
  endfunction : stepToward

  step_timer u_timer (
    .clk(clk),
    .rst(rst),
    .run(st_r.ramping),
    .rate(st_r.rate),
    .tick(stepTick)
  );

  // ---------------------------------------------------------------
  // Register writes, ramp engine and blanking
  // ---------------------------------------------------------------
  logic wr3, wrBb, wrRamp, startRamp, atTarget;

  always_comb begin
    st_nxt = st_r;
    st_nxt.strapSync = {st_r.strapSync[0], resistorDefaultSelect};
    wr3 = wrEn && unlocked && addr == OFS_BUCK3; // R1
    wrBb = wrEn && unlocked && addr == OFS_BUCKBOOST; // R1
    wrRamp = wrEn && addr == OFS_RAMP;
    startRamp = 1'b0;
    atTarget = st_r.act1 == railOneTarget && st_r.act2 == railTwoTarget;
    // Strap is caught once, after synchronising, before any write.
    if (!st_r.strapDone) begin // R7
      st_nxt.strapDone = 1'b1;
      if (st_r.strapSync[1]) begin
        st_nxt.buck3 = ALT_BUCK3;
        st_nxt.bboost = ALT_BUCKBOOST;
      end
    end
    if (wr3) begin
      st_nxt.buck3 = {wrData[LIGHT_LOAD_BIT], 1'b0, wrData[5:0]}; // R3 R4
    end
    if (wrBb) begin
      st_nxt.bboost = {wrData[LIGHT_LOAD_BIT], 1'b0, wrData[5:0]}; // R5
    end
    st_nxt.blank3 = (st_r.blank3 != '0) ? st_r.blank3 - 23'h1 : '0;
    st_nxt.blankBb = (st_r.blankBb != '0) ? st_r.blankBb - 23'h1 : '0;
    if (wr3) begin
      st_nxt.blank3 = 23'(BLANK_LEN); // R2
    end
    if (wrBb) begin
      st_nxt.blankBb = 23'(BLANK_LEN); // R2
    end
    st_nxt.blank3On = st_nxt.blank3 != '0;
    st_nxt.blankBbOn = st_nxt.blankBb != '0;
    if (wrRamp) begin
      st_nxt.autoApply = wrData[AUTO_APPLY_BIT];
      st_nxt.rate = wrData[2:0];
      if (wrData[TRIGGER_BIT]) begin // R10
        st_nxt.trig = 1'b1;
        startRamp = 1'b1;
      end
    end
    if (railTargetWrite && (st_nxt.autoApply)) begin // R12
      startRamp = 1'b1;
    end
    // Only rails one and two follow the ramp engine.
    if (startRamp || st_r.ramping) begin // R8
      if (st_nxt.rate == RATE_IMMEDIATE) begin // R14
        st_nxt.act1 = railOneTarget;
        st_nxt.act2 = railTwoTarget;
        st_nxt.ramping = 1'b0;
        st_nxt.trig = 1'b0; // R11
      end else if (atTarget && !startRamp) begin
        st_nxt.ramping = 1'b0; // R17
        st_nxt.trig = 1'b0; // R11
      end else begin
        st_nxt.ramping = 1'b1;
        if (stepTick) begin // R15 R17
          st_nxt.act1 = stepToward(st_r.act1, railOneTarget);
          st_nxt.act2 = stepToward(st_r.act2, railTwoTarget);
        end
      end
    end
    unique case (addr)
      OFS_BUCK3: st_nxt.rd = st_nxt.buck3;
      OFS_BUCKBOOST: st_nxt.rd = st_nxt.bboost;
      OFS_RAMP: st_nxt.rd = {st_nxt.trig, st_nxt.autoApply, 3'h0,
                             st_nxt.rate};
      default: st_nxt.rd = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.buck3 <= BUCK3_RESET;
      st_r.bboost <= BUCKBOOST_RESET;
      st_r.rate <= RAMP_RESET[2:0];
      // The strap synchroniser keeps sampling through reset.
      st_r.strapSync <= st_nxt.strapSync; // R7
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData = st_r.rd;
  assign railOneActive = st_r.act1;
  assign railTwoActive = st_r.act2;
  assign buckRailThree = st_r.buck3;
  assign buckboostRail = st_r.bboost;
  assign railThreeBlank = st_r.blank3On;
  assign buckboostBlank = st_r.blankBbOn;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence lockedWrite3;
    wrEn && !unlocked && addr == OFS_BUCK3;
  endsequence

  a_locked_write_ignored: assert property (@(posedge clk) disable iff (rst) // R1
    lockedWrite3 and st_r.strapDone |=> $stable(buckRailThree))
    else $error("locked write changed rail three");

  a_blank_starts: assert property (@(posedge clk) disable iff (rst) // R2
    wrEn && unlocked && addr == OFS_BUCKBOOST |=> buckboostBlank [*8])
    else $error("buck-boost blanking missing after write");

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst) // R3
    !buckRailThree[6] && !buckboostRail[6])
    else $error("reserved bit six set");

  a_ramp_one_step: assert property (@(posedge clk) disable iff (rst) // R17
    st_r.ramping && st_r.rate != RATE_IMMEDIATE |=>
      (railOneActive - $past(railOneActive) + 6'h01) <= 6'h02)
    else $error("rail one moved more than one code");

  a_trig_clears: assert property (@(posedge clk) disable iff (rst) // R11
    st_r.trig && st_r.ramping && atTarget && !startRamp |=> !st_r.trig)
    else $error("trigger did not clear");

  a_immediate_apply: assert property (@(posedge clk) disable iff (rst) // R14
    wrRamp && wrData[TRIGGER_BIT] && wrData[2:0] == RATE_IMMEDIATE |=>
      railOneActive == $past(railOneTarget))
    else $error("immediate rate did not apply target");

  a_no_auto_hold: assert property (@(posedge clk) disable iff (rst) // R12
    !st_r.ramping && !wrRamp && !st_r.autoApply |=>
      $stable(railOneActive))
    else $error("rail one moved without trigger");

  a_rate_reset: assert property (@(posedge clk) // R13
    rst |=> st_r.rate == RAMP_RESET[2:0])
    else $error("rate field reset wrong");

  a_blank_three: assert property (@(posedge clk) disable iff (rst) // R2
    wr3 |=> railThreeBlank [*8])
    else $error("rail three blanking missing after write");

  sequence trigWrite;
    wrRamp && wrData[TRIGGER_BIT] && wrData[2:0] != RATE_IMMEDIATE;
  endsequence

  a_trigger_starts: assert property (@(posedge clk) disable iff (rst) // R10
    trigWrite |=> st_r.trig && st_r.ramping)
    else $error("trigger write did not start a ramp");

endmodule : regulator_setpoint_slew_regs

// ### dv/regulator_setpoint_slew_regs_test.sv
`timescale 1ns/100ps
module regulator_setpoint_slew_regs_test;
  import setpoint_regs_pkg::*;
  localparam int BLEN = 20;
  localparam logic [7:0] ALT3 = 8'h92;
  localparam logic [7:0] ALTBB = 8'h8A;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wrEn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic [7:0] rdData;
  logic unlocked = 1'b0;
  logic [5:0] oneTgt = 6'h00;
  logic [5:0] twoTgt = 6'h00;
  logic tgtWr = 1'b0;
  logic strap = 1'b0;
  logic [5:0] oneAct;
  logic [5:0] twoAct;
  logic [7:0] threeReg;
  logic [7:0] bbReg;
  logic threeBlank;
  logic bbBlank;
  int fails = 0;
  int nCompared = 0;
  int cycles = 0;
  int n;

  regulator_setpoint_slew_regs #(
    .BLANK_LEN(BLEN),
    .ALT_BUCK3(ALT3),
    .ALT_BUCKBOOST(ALTBB)
  ) u_regulator_setpoint_slew_regs (
    .clk(clk), .rst(rst), .wrEn(wrEn), .addr(addr), .wrData(wrData),
    .rdData(rdData), .unlocked(unlocked), .resistorDefaultSelect(strap),
    .railOneTarget(oneTgt), .railTwoTarget(twoTgt),
    .railTargetWrite(tgtWr), .railOneActive(oneAct),
    .railTwoActive(twoAct), .buckRailThree(threeReg),
    .buckboostRail(bbReg), .railThreeBlank(threeBlank),
    .buckboostBlank(bbBlank));

  initial begin
    forever #25 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wrData = d;
    wrEn = 1'b1;
    tick(1);
    wrEn = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    tick(2);
    chk(rdData, exp);
  endtask : rd

  task automatic pulse_target();
    tgtWr = 1'b1;
    tick(1);
    tgtWr = 1'b0;
    tick(3);
  endtask : pulse_target

  // Waits with a ceiling for the trigger bit to drop; n holds the cycles.
  task automatic wait_ramp(input int lim);
    n = 0;
    while (rdData[TRIGGER_BIT] !== 1'b0 && n < lim) begin
      tick(1);
      n++;
    end
    chk(rdData & 8'h80, 8'h00);
  endtask : wait_ramp

  // ---------------------------------------------------------------
  // Hang guard
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails = fails + 1;
      complete_run();
    end
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(2);
    rd(OFS_BUCK3, 8'hBD);
    rd(OFS_BUCKBOOST, 8'h94);
    rd(OFS_RAMP, 8'h06);
    rd(8'h00, 8'h00);
    wr(OFS_BUCK3, 8'h00);
    rd(OFS_BUCK3, 8'hBD);
    unlocked = 1'b1;
    wr(OFS_BUCK3, 8'h7F);
    chk(threeReg, 8'h3F);
    chk({7'h00, threeBlank}, 8'h01);
    tick(BLEN - 3);
    chk({7'h00, threeBlank}, 8'h01);
    tick(5);
    chk({7'h00, threeBlank}, 8'h00);
    wr(OFS_BUCKBOOST, 8'hB4);
    chk(bbReg, 8'hB4);
    chk({6'h00, threeBlank, bbBlank}, 8'h01);
    rd(OFS_BUCKBOOST, 8'hB4);
    chk({2'h0, oneAct}, 8'h00);
    oneTgt = 6'h03;
    twoTgt = 6'h02;
    wr(OFS_RAMP, 8'h86);
    wait_ramp(400);
    chk({2'h0, oneAct}, 8'h03);
    chk({2'h0, twoAct}, 8'h02);
    for (int r = 0; r < 7; r++) begin
      int per;
      per = STEP_MIN_CYCLES << (6 - r);
      oneTgt = oneTgt + 6'h01;
      twoTgt = twoTgt + 6'h01;
      wr(OFS_RAMP, 8'h80 | 8'(r));
      wait_ramp(4000);
      chk(8'((n >= per - 3) && (n <= per + 3)), 8'h01);
      chk({2'h0, twoAct}, {2'h0, twoTgt});
    end
    oneTgt = 6'h20;
    twoTgt = 6'h05;
    wr(OFS_RAMP, 8'h87);
    tick(2);
    chk({2'h0, oneAct}, 8'h20);
    chk({2'h0, twoAct}, 8'h05);
    rd(OFS_RAMP, 8'h07);
    oneTgt = 6'h11;
    wr(OFS_RAMP, 8'h07);
    pulse_target();
    chk({2'h0, oneAct}, 8'h20);
    wr(OFS_RAMP, 8'h7F);
    rd(OFS_RAMP, 8'h47);
    pulse_target();
    chk({2'h0, oneAct}, 8'h11);
    strap = 1'b1;
    rst = 1'b1;
    tick(4);
    rst = 1'b0;
    tick(2);
    chk(threeReg, ALT3);
    chk(bbReg, ALTBB);
    rd(OFS_RAMP, 8'h06);
    complete_run();
  end
endmodule : regulator_setpoint_slew_regs_test
